// ===== rtl/mlp_regs.vh
// Constants for the memory low-power clock, reset and abort control.
// Assumes inclusion by bare name from the design files only.
`ifndef MLP_REGS_VH
`define MLP_REGS_VH

// Least reset hold, in cycles of the reset domain's clock
`define MLP_RST_MIN_CYC   16
// DFI frequency ratio: 1 means clk doubles as the DFI clock
`define MLP_FREQ_RATIO    1
// Default chip-select count and counter widths
`define MLP_NCS           4
`define MLP_IDLE_W        16
`define MLP_SRD_W         8
`define MLP_WAKE_W        4
// Chip-select clock mapping modes
`define MLP_MAP_SINGLE    2'h0
`define MLP_MAP_PAIR      2'h1
`define MLP_MAP_ALL       2'h2
// Per-chip power state bit positions (one-hot)
`define MLP_PS_READY      0
`define MLP_PS_CKSTOP     1
`define MLP_PS_PD         2
`define MLP_PS_SR         3
// Reset values of handshake outputs
`define MLP_QACCEPTN_RST  1'b1
`define MLP_QDENY_RST     1'b0
`define MLP_ABORT_ACK_RST 1'b0

`endif

// ===== rtl/mlp_sync.v
// Two-stage level synchroniser for inputs from the programming clock domain.
// Assumes the input may change at any time relative to clk.
`timescale 1ns/100ps
module mlp_sync #(
    parameter       RST_VAL = 1'b0
) (
    input  wire     clk,
    input  wire     rst_n,
    input  wire     d,
    output wire     q
);
    reg             meta_q;
    reg             sync_q;

    // First stage feeds only the second stage
    always @(posedge clk) begin
        if (!rst_n) begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
        end else begin
            meta_q <= d;
            sync_q <= meta_q;
        end
    end

    assign q = sync_q;
endmodule

// ===== rtl/mlp_cs_power.v
// Power state machine of one SDRAM chip select: idle timer, clock stop,
// power-down and self-refresh. Assumes refresh_tick pulses once a refresh period.
`timescale 1ns/100ps
`include "mlp_regs.vh"
module mlp_cs_power #(
    parameter       IW = `MLP_IDLE_W,
    parameter       SW = `MLP_SRD_W
) (
    input  wire          clk,
    input  wire          rst_n,
    input  wire          pd_en,
    input  wire          clk_stop_en,
    input  wire [IW-1:0] idle_limit,
    input  wire          sr_en,
    input  wire [SW-1:0] sr_delay,
    input  wire          refresh_tick,
    input  wire          cmd_pending,
    input  wire          force_sr,
    output reg  [3:0]    state_q,
    output reg           cke_q,
    output reg           ck_en_q
);
    localparam [3:0] S_READY  = 4'h1;
    localparam [3:0] S_CKSTOP = 4'h2;
    localparam [3:0] S_PD     = 4'h4;
    localparam [3:0] S_SR     = 4'h8;

    reg  [3:0]    state_d;
    reg  [IW-1:0] idle_q;
    reg  [SW-1:0] ref_q;
    wire          wake;
    wire          lp;

    assign wake = cmd_pending & ~force_sr;
    assign lp   = state_q[`MLP_PS_CKSTOP] | state_q[`MLP_PS_PD];

    // Next state
    always @* begin
        state_d = state_q;
        case (state_q)
            S_READY: begin
                if (force_sr)
                    state_d = S_SR;
                else if (pd_en && !cmd_pending && idle_q >= idle_limit)
                    state_d = clk_stop_en ? S_CKSTOP : S_PD;
            end
            S_CKSTOP, S_PD: begin
                if (force_sr || (sr_en && ref_q >= sr_delay))
                    state_d = S_SR;
                else if (wake)
                    state_d = S_READY;
            end
            S_SR: begin
                if (wake)
                    state_d = S_READY;
            end
            default: state_d = S_READY;
        endcase
    end

    // State, idle timer and refresh-period counter
    always @(posedge clk) begin
        if (!rst_n) begin
            state_q <= S_READY;
            idle_q  <= {IW{1'b0}};
            ref_q   <= {SW{1'b0}};
            cke_q   <= 1'b1;
            ck_en_q <= 1'b1;
        end else begin
            state_q <= state_d;
            if (cmd_pending || !state_q[`MLP_PS_READY])
                idle_q <= {IW{1'b0}};
            else if (idle_q != {IW{1'b1}})
                idle_q <= idle_q + 1'b1;
            if (!lp)
                ref_q <= {SW{1'b0}};
            else if (refresh_tick && ref_q != {SW{1'b1}})
                ref_q <= ref_q + 1'b1;
            cke_q   <= ~(state_d[`MLP_PS_PD] | state_d[`MLP_PS_SR]);
            ck_en_q <= ~(state_d[`MLP_PS_CKSTOP] | state_d[`MLP_PS_SR]);
        end
    end
endmodule

// ===== rtl/mlp_ctrl.v
// Clock, reset, low-power and abort control of a DDR3/DDR4 memory controller.
// Assumes one clock clk; programming-domain qreqn_apb, prog_busy and sw_lp_req arrive
// asynchronously and are synchronised here. Control bits are plain ports, no register bus.
`timescale 1ns/100ps
`include "mlp_regs.vh"
// Operation
// - Core reset clears main/DFI logic; programming reset clears programming logic.
// - In 1:1 mode clk also serves as the DFI clock.
// - Q-channel request, busy and software low-power crossings from the programming domain are synchronised.
// - Main quiesce puts SDRAM into self-refresh before accepting.
// - Gear-down mode denies main quiesce; software entry still works.
// - Programming-clock channel never denies, may delay on activity.
// - Only idle-ready allows SDRAM commands.
// - Separate clock and CKE per chip select with selectable mappings.
// - Automatic power-down uses an enable, idle timer and clock-stop select.
// - Self-refresh entry after programmed refresh periods; exit only on commands.
// - Low-power SDRAM requests PHY power-down with programmed wake-up value.
// - PHY power-down also on software command or Q-channel, own wake-up values.
// - Software may enter and leave low-power state through programming port.
// - Abort by four-phase handshake at any time enters abort state.
// - After abort, hold transactions until software orders a retry.
module mlp_ctrl #(
    parameter       NCS  = `MLP_NCS,
    parameter       IW   = `MLP_IDLE_W,
    parameter       SW   = `MLP_SRD_W,
    parameter       WW   = `MLP_WAKE_W
) (
    input  wire           clk,
    input  wire           core_domain_reset_low,
    input  wire           prog_reset_low,
    // Main clock Q-channel
    input  wire           qreqn,
    output reg            qacceptn,
    output reg            qdeny,
    output reg            qactive,
    // Programming clock Q-channel
    input  wire           qreqn_apb,
    output reg            qacceptn_apb,
    output reg            qdeny_apb,
    output reg            qactive_apb,
    input  wire           prog_busy,
    // Configuration from the programming port
    input  wire           geardown_en,
    input  wire           pd_en,
    input  wire           clk_stop_en,
    input  wire [IW-1:0]  idle_limit,
    input  wire           sr_en,
    input  wire [SW-1:0]  sr_delay,
    input  wire [1:0]     cs_map_mode,
    input  wire           maximum_power_saving_state_en,
    input  wire [WW-1:0]  wake_pd,
    input  wire [WW-1:0]  wake_sr,
    input  wire [WW-1:0]  wake_maximum_power_saving_state,
    input  wire [WW-1:0]  wake_qch_tie,
    input  wire           sw_lp_req,
    input  wire           sw_phy_pd_req,
    input  wire [WW-1:0]  sw_phy_wake,
    input  wire           sw_retry,
    // Scheduler side
    input  wire           refresh_tick,
    input  wire [NCS-1:0] cs_cmd_pending,
    output reg  [NCS-1:0] cs_cmd_allow,
    output reg  [NCS-1:0] sdram_cke,
    output reg  [NCS-1:0] sdram_ck_en,
    output reg            sw_lp_ack,
    output reg            phy_pd_req,
    output reg  [WW-1:0]  phy_pd_wake,
    // Abort
    input  wire           abort_req,
    output reg            abort_ack,
    output reg            abort_state,
    output reg            txn_hold,
    output reg            retry_go
);
    // Main Q-channel states
    localparam [4:0] Q_RUN   = 5'h01;
    localparam [4:0] Q_ENTER = 5'h02;
    localparam [4:0] Q_STOP  = 5'h04;
    localparam [4:0] Q_DENY  = 5'h08;
    localparam [4:0] Q_EXIT  = 5'h10;
    // Programming Q-channel states
    localparam [1:0] P_RUN   = 2'h1;
    localparam [1:0] P_STOP  = 2'h2;

    reg  [4:0]     q_state_q;
    reg  [4:0]     q_state_d;
    reg  [1:0]     p_state_q;
    reg  [1:0]     p_state_d;
    reg            abort_req_q;
    reg  [NCS-1:0] ck_map;
    wire [4*NCS-1:0] cs_state;
    wire [NCS-1:0] cs_cke;
    wire [NCS-1:0] cs_ck;
    wire [NCS-1:0] cs_in_sr;
    wire [NCS-1:0] cs_ready;
    wire           force_sr;
    wire           all_sr;
    wire           all_lp;
    wire           qreqn_apb_s;
    wire           prog_busy_s;
    wire           sw_lp_s;
    integer        i;

    // Programming-domain levels cross through two-flop synchronisers
    mlp_sync #(.RST_VAL(1'b1)) u_sync_qreqn_apb (
        .clk   (clk),
        .rst_n (prog_reset_low),
        .d     (qreqn_apb),
        .q     (qreqn_apb_s)
    );
    mlp_sync #(.RST_VAL(1'b0)) u_sync_busy (
        .clk   (clk),
        .rst_n (prog_reset_low),
        .d     (prog_busy),
        .q     (prog_busy_s)
    );
    mlp_sync #(.RST_VAL(1'b0)) u_sync_swlp (
        .clk   (clk),
        .rst_n (core_domain_reset_low),
        .d     (sw_lp_req),
        .q     (sw_lp_s)
    );

    // Self-refresh is forced by a quiesce or by software entry
    assign force_sr = (q_state_q == Q_ENTER) | (q_state_q == Q_STOP) | sw_lp_s;

    // One power state machine per chip select
    genvar g;
    generate
        for (g = 0; g < NCS; g = g + 1) begin : g_cs
            mlp_cs_power #(.IW(IW), .SW(SW)) u_cs (
                .clk          (clk),
                .rst_n        (core_domain_reset_low),
                .pd_en        (pd_en),
                .clk_stop_en  (clk_stop_en),
                .idle_limit   (idle_limit),
                .sr_en        (sr_en),
                .sr_delay     (sr_delay),
                .refresh_tick (refresh_tick),
                .cmd_pending  (cs_cmd_pending[g]),
                .force_sr     (force_sr),
                .state_q      (cs_state[4*g+3:4*g]),
                .cke_q        (cs_cke[g]),
                .ck_en_q      (cs_ck[g])
            );
            assign cs_in_sr[g] = cs_state[4*g+`MLP_PS_SR];
            assign cs_ready[g] = cs_state[4*g+`MLP_PS_READY];
        end
    endgenerate

    assign all_sr = &cs_in_sr;
    assign all_lp = ~|cs_ready;

    // Clock mapping: a shared clock runs while any chip sharing it needs it
    always @* begin
        ck_map = cs_ck;
        for (i = 0; i < NCS; i = i + 1) begin
            case (cs_map_mode)
                `MLP_MAP_PAIR: ck_map[i] = cs_ck[i] | cs_ck[i ^ 1];
                `MLP_MAP_ALL:  ck_map[i] = |cs_ck;
                default:       ck_map[i] = cs_ck[i];
            endcase
        end
    end

    // Main Q-channel next state
    always @* begin
        q_state_d = q_state_q;
        case (q_state_q)
            Q_RUN: begin
                if (!qreqn)
                    q_state_d = geardown_en ? Q_DENY : Q_ENTER;
            end
            Q_ENTER: begin
                if (all_sr)
                    q_state_d = Q_STOP;
            end
            Q_STOP: begin
                if (qreqn)
                    q_state_d = Q_EXIT;
            end
            Q_DENY: begin
                if (qreqn)
                    q_state_d = Q_RUN;
            end
            // A new request may follow as soon as acceptance is withdrawn
            Q_EXIT: begin
                if (!qreqn)
                    q_state_d = geardown_en ? Q_DENY : Q_ENTER;
                else
                    q_state_d = Q_RUN;
            end
            default: q_state_d = Q_RUN;
        endcase
    end

    // Main Q-channel outputs; accept and deny are never both shown
    always @(posedge clk) begin
        if (!core_domain_reset_low) begin
            q_state_q <= Q_RUN;
            qacceptn  <= `MLP_QACCEPTN_RST;
            qdeny     <= `MLP_QDENY_RST;
            qactive   <= 1'b0;
        end else begin
            q_state_q <= q_state_d;
            qacceptn  <= ~(q_state_d == Q_STOP);
            qdeny     <= (q_state_d == Q_DENY);
            qactive   <= (|cs_cmd_pending) | abort_req | prog_busy_s;
        end
    end

    // Programming Q-channel next state, acceptance waits for idle port
    always @* begin
        p_state_d = p_state_q;
        case (p_state_q)
            P_RUN: begin
                if (!qreqn_apb_s && !prog_busy_s)
                    p_state_d = P_STOP;
            end
            P_STOP: begin
                if (qreqn_apb_s)
                    p_state_d = P_RUN;
            end
            default: p_state_d = P_RUN;
        endcase
    end

    // Programming-domain state is cleared by its own reset
    always @(posedge clk) begin
        if (!prog_reset_low) begin
            p_state_q    <= P_RUN;
            qacceptn_apb <= `MLP_QACCEPTN_RST;
            qdeny_apb    <= `MLP_QDENY_RST;
            qactive_apb  <= 1'b0;
        end else begin
            p_state_q    <= p_state_d;
            qacceptn_apb <= ~(p_state_d == P_STOP);
            qdeny_apb    <= 1'b0;
            qactive_apb  <= prog_busy_s | ~qreqn | (|cs_cmd_pending);
        end
    end

    // SDRAM pins, command permission, software entry and PHY power-down
    always @(posedge clk) begin
        if (!core_domain_reset_low) begin
            cs_cmd_allow <= {NCS{1'b0}};
            sdram_cke    <= {NCS{1'b1}};
            sdram_ck_en  <= {NCS{1'b1}};
            sw_lp_ack    <= 1'b0;
            phy_pd_req   <= 1'b0;
            phy_pd_wake  <= {WW{1'b0}};
        end else begin
            cs_cmd_allow <= cs_ready;
            sdram_cke    <= cs_cke;
            sdram_ck_en  <= ck_map;
            sw_lp_ack    <= sw_lp_s & all_sr;
            if (q_state_q == Q_ENTER || q_state_q == Q_STOP) begin
                phy_pd_req  <= all_sr;
                phy_pd_wake <= wake_qch_tie;
            end else if (sw_phy_pd_req) begin
                phy_pd_req  <= 1'b1;
                phy_pd_wake <= sw_phy_wake;
            end else if (all_lp) begin
                phy_pd_req  <= 1'b1;
                if (!all_sr)
                    phy_pd_wake <= wake_pd;
                else if (maximum_power_saving_state_en)
                    phy_pd_wake <= wake_maximum_power_saving_state;
                else
                    phy_pd_wake <= wake_sr;
            end else begin
                phy_pd_req  <= 1'b0;
                phy_pd_wake <= {WW{1'b0}};
            end
        end
    end

    // Abort four-phase handshake and transaction hold
    always @(posedge clk) begin
        if (!core_domain_reset_low) begin
            abort_req_q <= 1'b0;
            abort_ack   <= `MLP_ABORT_ACK_RST;
            abort_state <= 1'b0;
            txn_hold    <= 1'b0;
            retry_go    <= 1'b0;
        end else begin
            abort_req_q <= abort_req;
            abort_ack   <= abort_req;
            retry_go    <= 1'b0;
            if (abort_req && !abort_req_q) begin
                abort_state <= 1'b1;
                txn_hold    <= 1'b1;
            end else if (abort_state && sw_retry && !abort_req) begin
                abort_state <= 1'b0;
                txn_hold    <= 1'b0;
                retry_go    <= 1'b1;
            end
        end
    end
endmodule

// ===== verification/mlp_ctrl_chk.sv
// Checker for the low-power clock, reset and abort control.
// Assumes binding to mlp_ctrl; both resets are synchronous to clk.
`timescale 1ns/100ps
module mlp_ctrl_chk #(
    parameter NCS = 4,
    parameter WW  = 4
) (
    input wire           clk,
    input wire           core_domain_reset_low,
    input wire           prog_reset_low,
    input wire           qreqn,
    input wire           qacceptn,
    input wire           qdeny,
    input wire           qdeny_apb,
    input wire           geardown_en,
    input wire           sw_retry,
    input wire [NCS-1:0] sdram_cke,
    input wire [NCS-1:0] cs_cmd_allow,
    input wire           phy_pd_req,
    input wire [WW-1:0]  phy_pd_wake,
    input wire [WW-1:0]  wake_qch_tie,
    input wire           abort_req,
    input wire           abort_ack,
    input wire           abort_state,
    input wire           txn_hold,
    input wire           retry_go
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!core_domain_reset_low);
    // Abort taken: acknowledge, state and hold rise together
    sequence s_abort_on;
        abort_ack && abort_state && txn_hold;
    endsequence
    // Retry order: a single pulse
    sequence s_retry_pulse;
        retry_go ##1 !retry_go;
    endsequence
    // Main and programming quiesce channels
    AST_ONE_ANSWER: assert property (qacceptn || !qdeny)
        else $error("accept and deny together");
    AST_ACCEPT_SR: assert property ($fell(qacceptn) |-> sdram_cke == '0 && cs_cmd_allow == '0)
        else $error("accept before self-refresh");
    AST_GEAR_DENY: assert property ($fell(qreqn) && geardown_en |=> qdeny && qacceptn)
        else $error("gear-down request not denied");
    AST_DENY_HOLD: assert property (qdeny && !qreqn |=> qdeny)
        else $error("deny dropped early");
    AST_ACCEPT_END: assert property ($rose(qreqn) && !qacceptn |=> qacceptn)
        else $error("accept not withdrawn");
    AST_QCH_PHY: assert property (!qacceptn |-> phy_pd_req && phy_pd_wake == wake_qch_tie)
        else $error("quiesce PHY request wrong");
    AST_APB_NO_DENY: assert property (@(posedge clk) disable iff (!prog_reset_low) !qdeny_apb)
        else $error("programming channel denied");
    // Chip power and abort
    AST_READY_CKE: assert property ((cs_cmd_allow & ~sdram_cke) == '0)
        else $error("commands allowed in low power");
    AST_ABORT_TAKE: assert property ($rose(abort_req) |=> s_abort_on)
        else $error("abort not taken");
    AST_ACK_DROP: assert property ($fell(abort_req) && abort_ack |=> !abort_ack)
        else $error("abort ack stuck");
    AST_HOLD_ABORT: assert property (abort_state && (abort_req || !sw_retry) |=> abort_state && txn_hold)
        else $error("abort left without retry");
    AST_RETRY: assert property (abort_state && !abort_req && sw_retry |=> s_retry_pulse)
        else $error("retry pulse missing");
endmodule

bind mlp_ctrl mlp_ctrl_chk #(.NCS(NCS), .WW(WW)) u_chk (
    .clk, .core_domain_reset_low, .prog_reset_low, .qreqn, .qacceptn, .qdeny, .qdeny_apb,
    .geardown_en, .sw_retry, .sdram_cke, .cs_cmd_allow, .phy_pd_req, .phy_pd_wake, .wake_qch_tie,
    .abort_req, .abort_ack, .abort_state, .txn_hold, .retry_go
);

// ===== verification/mlp_pwr_partner.sv
// Model of the system power controller and abort requester.
// Assumes go levels from the bench; requests change at the falling edge.
`timescale 1ns/100ps
module mlp_pwr_partner (
    input  wire clk,
    input  wire rst_n,
    input  wire go_q,
    input  wire go_apb,
    input  wire go_abort,
    input  wire qacceptn,
    input  wire qdeny,
    input  wire qactive,
    input  wire qacceptn_apb,
    input  wire abort_ack,
    output reg  qreqn,
    output reg  qreqn_apb,
    output reg  abort_req
);
    // Four-phase requests; each waits for the previous answer to clear
    always @(negedge clk) begin
        if (!rst_n) begin
            qreqn     <= 1'b1;
            qreqn_apb <= 1'b1;
            abort_req <= 1'b0;
        end else begin
            if (qreqn && qacceptn && !qdeny && go_q) qreqn <= 1'b0;
            else if (!qreqn && (!qacceptn || qdeny) && (!go_q || qactive)) qreqn <= 1'b1;
            if (qreqn_apb && qacceptn_apb && go_apb) qreqn_apb <= 1'b0;
            else if (!qreqn_apb && !qacceptn_apb && !go_apb) qreqn_apb <= 1'b1;
            if (!abort_req && !abort_ack && go_abort) abort_req <= 1'b1;
            else if (abort_req && abort_ack && !go_abort) abort_req <= 1'b0;
        end
    end
endmodule

// ===== verification/tb.sv
// Self-checking bench for the low-power clock, reset and abort control.
// Assumes the partner model drives the handshake requests.
`timescale 1ns/100ps
module tb;
    logic        clk, core_domain_reset_low, prog_reset_low, prog_busy, geardown_en, pd_en, clk_stop_en;
    logic        sr_en, maximum_power_saving_state_en, sw_lp_req, sw_phy_pd_req, sw_retry, refresh_tick;
    logic        go_q, go_apb, go_abort;
    logic [15:0] idle_limit;
    logic [7:0]  sr_delay;
    logic [1:0]  cs_map_mode;
    logic [3:0]  wake_pd, wake_sr, wake_maximum_power_saving_state, wake_qch_tie, sw_phy_wake, cs_cmd_pending;
    wire         qreqn, qreqn_apb, abort_req, qacceptn, qdeny, qactive, qacceptn_apb, qdeny_apb, qactive_apb;
    wire         sw_lp_ack, phy_pd_req, abort_ack, abort_state, txn_hold, retry_go;
    wire  [3:0]  cs_cmd_allow, sdram_cke, sdram_ck_en, phy_pd_wake;
    int          fail_count, comparisons, m;

    mlp_ctrl u_dut (
        .clk, .core_domain_reset_low, .prog_reset_low, .qreqn, .qacceptn, .qdeny, .qactive, .qreqn_apb,
        .qacceptn_apb, .qdeny_apb, .qactive_apb, .prog_busy, .geardown_en, .pd_en, .clk_stop_en, .idle_limit,
        .sr_en, .sr_delay, .cs_map_mode, .maximum_power_saving_state_en, .wake_pd, .wake_sr,
        .wake_maximum_power_saving_state, .wake_qch_tie, .sw_lp_req, .sw_phy_pd_req, .sw_phy_wake, .sw_retry,
        .refresh_tick, .cs_cmd_pending, .cs_cmd_allow, .sdram_cke, .sdram_ck_en, .sw_lp_ack, .phy_pd_req,
        .phy_pd_wake, .abort_req, .abort_ack, .abort_state, .txn_hold, .retry_go
    );
    mlp_pwr_partner u_partner (
        .clk, .rst_n(core_domain_reset_low), .go_q, .go_apb, .go_abort, .qacceptn, .qdeny, .qactive,
        .qacceptn_apb, .abort_ack, .qreqn, .qreqn_apb, .abort_req
    );

    // Compare and count
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Advance n falling edges
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Expected clock enables for a mapping mode and awake chips
    function automatic logic [3:0] exp_ck(input int mode, input logic [3:0] on);
        if (mode == 0) return on;
        if (mode == 1) return on | {on[2], on[3], on[0], on[1]};
        return (on != 4'h0) ? 4'hf : 4'h0;
    endfunction
    // Print the verdict and stop
    task automatic give_verdict;
        if (fail_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // Clock at 200 MHz; in 1:1 mode it is also the DFI clock, no second clock is made
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Hang guard, far beyond the expected run
    initial begin
        #100000;
        fail_count++;
        give_verdict();
    end
    // Main sequence
    initial begin
        m = $urandom(31657);
        {prog_busy, geardown_en, pd_en, clk_stop_en, sr_en, maximum_power_saving_state_en} = '0;
        {sw_lp_req, sw_phy_pd_req, sw_retry, refresh_tick, go_q, go_apb, go_abort} = '0;
        {idle_limit, sr_delay, cs_map_mode, cs_cmd_pending} = '0;
        wake_pd = 4'($urandom);
        wake_sr = ~wake_pd;
        wake_maximum_power_saving_state = 4'($urandom);
        wake_qch_tie = 4'($urandom);
        sw_phy_wake = 4'($urandom);
        core_domain_reset_low = 1'b0;
        prog_reset_low = 1'b0;
        cyc(17);
        prog_reset_low <= 1'b1;
        cyc(2);
        core_domain_reset_low <= 1'b1;
        cyc(2);
        chk({qacceptn, qdeny, abort_ack, abort_state, qacceptn_apb, qdeny_apb, phy_pd_req}, 7'h44);
        chk(cs_cmd_allow, 4'hf);
        // Hardware quiesce, then wake one chip only
        go_q <= 1'b1;
        repeat (30) if (qacceptn !== 1'b0) cyc(1);
        chk({qacceptn, sdram_cke, cs_cmd_allow, phy_pd_req, qactive}, 11'h002);
        chk(phy_pd_wake, wake_qch_tie);
        go_q <= 1'b0;
        repeat (10) if (qacceptn !== 1'b1) cyc(1);
        cs_cmd_pending <= 4'h1;
        repeat (30) if (cs_cmd_allow[0] !== 1'b1) cyc(1);
        chk(cs_cmd_allow, 4'h1);
        cs_cmd_pending <= 4'hf;
        repeat (30) if (cs_cmd_allow !== 4'hf) cyc(1);
        // Gear-down denies; with no pending work the request and deny are held
        geardown_en <= 1'b1;
        cs_cmd_pending <= 4'h0;
        go_q <= 1'b1;
        repeat (10) if (qdeny !== 1'b1) cyc(1);
        chk({qdeny, qacceptn}, 2'h3);
        cyc(3);
        chk({qdeny, qacceptn, qreqn}, 3'h6);
        go_q <= 1'b0;
        repeat (10) if (qdeny !== 1'b0) cyc(1);
        chk({qdeny, qacceptn, cs_cmd_allow}, 6'h1f);
        maximum_power_saving_state_en <= 1'b1;
        sw_lp_req <= 1'b1;
        repeat (40) if (sw_lp_ack !== 1'b1) cyc(1);
        chk({sw_lp_ack, sdram_cke}, 5'h10);
        chk({phy_pd_req, phy_pd_wake}, {1'b1, wake_maximum_power_saving_state});
        sw_lp_req <= 1'b0;
        cs_cmd_pending <= 4'hf;
        repeat (40) if (cs_cmd_allow !== 4'hf) cyc(1);
        chk({sw_lp_ack, cs_cmd_allow}, 5'h0f);
        geardown_en <= 1'b0;
        maximum_power_saving_state_en <= 1'b0;
        // Software PHY power-down while chips are ready
        sw_phy_pd_req <= 1'b1;
        cyc(4);
        chk({phy_pd_req, phy_pd_wake}, {1'b1, sw_phy_wake});
        sw_phy_pd_req <= 1'b0;
        cyc(4);
        chk(phy_pd_req, 1'b0);
        // Programming channel delays while busy, never denies
        prog_busy <= 1'b1;
        go_apb <= 1'b1;
        cyc(10);
        chk({qacceptn_apb, qdeny_apb, qactive_apb, qactive}, 4'hb);
        prog_busy <= 1'b0;
        repeat (10) if (qacceptn_apb !== 1'b0) cyc(1);
        chk({qacceptn_apb, qdeny_apb}, 2'h0);
        go_apb <= 1'b0;
        repeat (10) if (qacceptn_apb !== 1'b1) cyc(1);
        chk(qacceptn_apb, 1'b1);
        // Abort, early retry ignored, then retry
        go_abort <= 1'b1;
        repeat (5) if (abort_ack !== 1'b1) cyc(1);
        sw_retry <= 1'b1;
        cyc(3);
        chk({abort_ack, abort_state, txn_hold, retry_go}, 4'he);
        sw_retry <= 1'b0;
        go_abort <= 1'b0;
        repeat (5) if (abort_ack !== 1'b0) cyc(1);
        chk({abort_ack, abort_state}, 2'h1);
        sw_retry <= 1'b1;
        repeat (5) if (retry_go !== 1'b1) cyc(1);
        chk({retry_go, abort_state, txn_hold}, 3'h4);
        sw_retry <= 1'b0;
        // Automatic power-down, then self-refresh
        idle_limit <= 16'(4 + $urandom_range(15));
        pd_en <= 1'b1;
        cs_cmd_pending <= 4'h0;
        cyc(1);
        for (m = 0; m < 60 && sdram_cke !== 4'h0; m++) cyc(1);
        chk(m >= idle_limit && m <= idle_limit + 3, 1'b1);
        chk({cs_cmd_allow, phy_pd_req, phy_pd_wake}, {5'h01, wake_pd});
        sr_en <= 1'b1;
        sr_delay <= 8'(1 + $urandom_range(2));
        for (m = 0; m < 64 && phy_pd_wake !== wake_sr; m++) begin
            refresh_tick <= (m % 4 == 0);
            cyc(1);
        end
        chk({phy_pd_req, phy_pd_wake}, {1'b1, wake_sr});
        sr_en <= 1'b0;
        refresh_tick <= 1'b0;
        // Clock stop under each chip-select mapping
        clk_stop_en <= 1'b1;
        for (m = 0; m < 3; m++) begin
            cs_map_mode <= 2'(m);
            cs_cmd_pending <= 4'hf;
            cyc(20);
            cs_cmd_pending <= 4'h0;
            cyc(40);
            chk(sdram_ck_en, exp_ck(m, 4'h0));
            cs_cmd_pending <= 4'h1;
            cyc(10);
            chk(sdram_ck_en, exp_ck(m, 4'h1));
        end
        give_verdict();
    end
endmodule
